/* design/stsc_ctrl.sv */
/*
  device-side controller of a parasite-powered single-wire temperature
  sensor: slot engine, selection and memory command decode, scratchpad,
  trigger bytes and check generator.
  assumes the data pin is open drain (dq_oe pulls it low) and the
  measurement front end offers temp_code and counts on ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "stsc_params.svh"

module stsc_ctrl #(
  parameter logic [7:0]  FAMILY    = 8'h5A,        // arbitrary value
  parameter logic [47:0] SERIAL    = 48'h0123456789AB, // arbitrary value
  parameter int          RST_CYC   = `STSC_UP(`STSC_RST_MIN_NS),
  parameter int          PRES_LEN  = `STSC_UP(`STSC_PRES_LEN_NS),
  parameter int          CONV_CYC  = `STSC_UP(`STSC_CONV_NS),
  parameter int          COPY_CYC  = `STSC_UP(`STSC_COPY_NS),
  parameter logic [7:0]  OP_RDID   = `STSC_OP_READ_ID,
  parameter logic [7:0]  OP_MATCH  = `STSC_OP_MATCH_ID,
  parameter logic [7:0]  OP_SRCH   = `STSC_OP_SEARCH_ID,
  parameter logic [7:0]  OP_SKIP   = `STSC_OP_SKIP_ID,
  parameter logic [7:0]  OP_ASRCH  = `STSC_OP_ALARM_SRCH,
  parameter logic [7:0]  OP_CONV   = `STSC_OP_CONVERT,
  parameter logic [7:0]  OP_RDSP   = `STSC_OP_RD_SCRATCH,
  parameter logic [7:0]  OP_WRSP   = `STSC_OP_WR_SCRATCH,
  parameter logic [7:0]  OP_COPY   = `STSC_OP_COPY,
  parameter logic [7:0]  OP_RECALL = `STSC_OP_RECALL
) (
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic       dq_in,
  output logic            dq_out,
  output logic            dq_oe,
  input  wire logic [8:0] temp_code,
  input  wire logic [7:0] cnt_remain,
  input  wire logic [7:0] cnt_per_c,
  output logic            conv_active,
  input  wire logic [1:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic [7:0]      reg_rdata
);

  localparam int SAMPLE_CYC = `STSC_UP(`STSC_SAMPLE_NS);
  localparam int TXH_CYC    = `STSC_DN(`STSC_TX_HOLD_NS);
  localparam int PWAIT_CYC  = `STSC_UP(`STSC_PRES_WAIT_NS);
  localparam int CW         = 24;
  localparam int TW         = 28;

  // lsb-first shift through x^8+x^5+x^4+1, zero start
  function automatic logic [7:0] crc8(input logic [63:0] d,
                                      input int n);
    logic [7:0] c;
    logic       fb;
    c  = 8'h00;
    fb = 1'b0;
    for (int i = 0; i < 64; i++) begin
      if (i < n) begin
        fb = c[0] ^ d[i];
        c  = {1'b0, c[7:1]} ^ ({8{fb}} & `STSC_CRC_POLY);
      end
    end
    return c;
  endfunction : crc8

  localparam logic [55:0] ID56   = {SERIAL, FAMILY};
  localparam logic [63:0] ROM_ID = {crc8({8'h00, ID56}, 56), ID56};

  stsc_pkg::stsc_state_t st_r;
  logic           dq_s1_r;
  logic           dq_s2_r;
  logic           dq_d_r;
  logic [CW-1:0]  low_cnt_r;
  logic [CW-1:0]  slot_cnt_r;
  logic [CW-1:0]  pres_cnt_r;
  logic [CW-1:0]  tx_cnt_r;
  logic           slot_act_r;
  logic           bit_stb;
  logic           bit_rx;
  logic           rst_det;
  logic           fall;
  logic           rise;
  logic           tx_en;
  logic           tx_val;
  logic [71:0]    sh_r;
  logic [7:0]     cmd_r;
  logic [6:0]     cnt_r;
  logic [1:0]     ph_r;
  logic [7:0]     op;
  logic           rom_dec;
  logic           fn_dec;
  logic           go_conv;
  logic           go_copy;
  logic [TW-1:0]  busy_cnt_r;
  logic           conv_r;
  logic [8:0]     temp_r;
  logic [7:0]     crem_r;
  logic [7:0]     cpc_r;
  logic           alarm_r;
  logic [7:0]     upper_limit_trigger_r;
  logic [7:0]     lower_limit_trigger_r;
  logic [7:0]     upper_limit_trigger_ee_r;
  logic [7:0]     lower_limit_trigger_ee_r;
  logic [7:0]     ctrl_r;
  logic [63:0]    pad;
  logic [71:0]    nx;
  logic           id_bit;

  // bus sampling; only the second and third flops are looked at
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      dq_s1_r <= 1'b1;
      dq_s2_r <= 1'b1;
      dq_d_r  <= 1'b1;
    end else begin
      dq_s1_r <= dq_in;
      dq_s2_r <= dq_s1_r;
      dq_d_r  <= dq_s2_r;
    end
  end

  assign fall    = dq_d_r & ~dq_s2_r;
  assign rise    = ~dq_d_r & dq_s2_r;
  assign rst_det = rise && (low_cnt_r >= CW'(RST_CYC)) && ctrl_r[0];
  assign bit_stb = slot_act_r && (slot_cnt_r == CW'(SAMPLE_CYC));
  assign bit_rx  = dq_s2_r;

  // slot timing counts; a long low is a bus reset
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      low_cnt_r  <= '0;
      slot_cnt_r <= '0;
      slot_act_r <= 1'b0;
    end else begin
      if (fall) begin
        low_cnt_r <= '0;
      end else if (!dq_s2_r && low_cnt_r != '1) begin
        low_cnt_r <= low_cnt_r + 1'b1;
      end
      if (fall && pres_cnt_r == '0) begin
        slot_cnt_r <= '0;
        slot_act_r <= 1'b1;
      end else if (slot_act_r) begin
        slot_cnt_r <= slot_cnt_r + 1'b1;
        if (bit_stb) begin
          slot_act_r <= 1'b0;
        end
      end
    end
  end

  // presence pulse after a reset, own falling edges are not slots
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pres_cnt_r <= '0;
    end else if (rst_det) begin
      pres_cnt_r <= CW'(PWAIT_CYC + PRES_LEN);
    end else if (pres_cnt_r != '0) begin
      pres_cnt_r <= pres_cnt_r - 1'b1;
    end
  end

  // a zero sent in a read slot holds the line low
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      tx_cnt_r <= '0;
    end else if (fall && pres_cnt_r == '0 && tx_en && !tx_val) begin
      tx_cnt_r <= CW'(TXH_CYC);
    end else if (tx_cnt_r != '0) begin
      tx_cnt_r <= tx_cnt_r - 1'b1;
    end
  end

  assign dq_out = 1'b0;
  assign dq_oe  = (tx_cnt_r != '0) ||
                  (pres_cnt_r != '0 && pres_cnt_r <= CW'(PRES_LEN));

  assign id_bit = ROM_ID[cnt_r[5:0]];

  always_comb begin
    tx_en  = 1'b0;
    tx_val = 1'b1;
    case (st_r)
      stsc_pkg::ST_READID,
      stsc_pkg::ST_RDSP: begin
        tx_en  = 1'b1;
        tx_val = sh_r[0];
      end
      stsc_pkg::ST_SEARCH: begin
        tx_en  = (ph_r != 2'd2);
        tx_val = (ph_r == 2'd0) ? id_bit : ~id_bit;
      end
      stsc_pkg::ST_BUSY: begin
        tx_en  = 1'b1;
        tx_val = 1'b0;
      end
      default: begin
        tx_en  = 1'b0;
        tx_val = 1'b1;
      end
    endcase
  end

  assign op      = {bit_rx, cmd_r[7:1]};
  assign rom_dec = bit_stb && st_r == stsc_pkg::ST_ROMCMD && cnt_r == 7'd7;
  assign fn_dec  = bit_stb && st_r == stsc_pkg::ST_FNCMD && cnt_r == 7'd7;
  assign go_conv = fn_dec && op == OP_CONV;
  assign go_copy = fn_dec && op == OP_COPY;
  assign nx      = {bit_rx, sh_r[71:1]};

  // scratchpad image, sign copied through the upper byte
  assign pad = {cpc_r, crem_r, `STSC_PAD_BYTE, `STSC_PAD_BYTE,
                lower_limit_trigger_r, upper_limit_trigger_r,
                {8{temp_r[8]}}, temp_r[7:0]};

  // command sequencer
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      st_r  <= stsc_pkg::ST_IDLE;
      sh_r  <= '0;
      cmd_r <= '0;
      cnt_r <= '0;
      ph_r  <= '0;
    end else if (rst_det) begin
      st_r  <= stsc_pkg::ST_ROMCMD;
      cnt_r <= '0;
      ph_r  <= '0;
    end else if (st_r == stsc_pkg::ST_BUSY && busy_cnt_r == '0) begin
      st_r <= stsc_pkg::ST_DONE;
    end else if (bit_stb) begin
      case (st_r)
        stsc_pkg::ST_ROMCMD: begin
          cmd_r <= op;
          cnt_r <= cnt_r + 7'd1;
          if (rom_dec) begin
            cnt_r <= '0;
            ph_r  <= '0;
            sh_r  <= {8'h00, ROM_ID};
            if (op == OP_RDID) begin
              st_r <= stsc_pkg::ST_READID;
            end else if (op == OP_MATCH) begin
              st_r <= stsc_pkg::ST_MATCH;
            end else if (op == OP_SRCH) begin
              st_r <= stsc_pkg::ST_SEARCH;
            end else if (op == OP_ASRCH && alarm_r) begin
              st_r <= stsc_pkg::ST_SEARCH;
            end else if (op == OP_SKIP) begin
              st_r <= stsc_pkg::ST_FNCMD;
            end else begin
              st_r <= stsc_pkg::ST_IDLE;
            end
          end
        end
        stsc_pkg::ST_READID: begin
          sh_r  <= {1'b0, sh_r[71:1]};
          cnt_r <= cnt_r + 7'd1;
          if (cnt_r == 7'd63) begin
            st_r  <= stsc_pkg::ST_FNCMD;
            cnt_r <= '0;
          end
        end
        stsc_pkg::ST_MATCH: begin
          cnt_r <= cnt_r + 7'd1;
          if (bit_rx != id_bit) begin
            st_r <= stsc_pkg::ST_IDLE;
          end else if (cnt_r == 7'd63) begin
            st_r  <= stsc_pkg::ST_FNCMD;
            cnt_r <= '0;
          end
        end
        stsc_pkg::ST_SEARCH: begin
          ph_r <= ph_r + 2'd1;
          if (ph_r == 2'd2) begin
            ph_r  <= '0;
            cnt_r <= cnt_r + 7'd1;
            if (bit_rx != id_bit) begin
              st_r <= stsc_pkg::ST_IDLE;
            end else if (cnt_r == 7'd63) begin
              st_r  <= stsc_pkg::ST_FNCMD;
              cnt_r <= '0;
            end
          end
        end
        stsc_pkg::ST_FNCMD: begin
          cmd_r <= op;
          cnt_r <= cnt_r + 7'd1;
          if (fn_dec) begin
            cnt_r <= '0;
            if (go_conv || go_copy) begin
              st_r <= stsc_pkg::ST_BUSY;
            end else if (op == OP_RDSP) begin
              st_r <= stsc_pkg::ST_RDSP;
              sh_r <= {crc8(pad, 64), pad};
            end else if (op == OP_WRSP) begin
              st_r <= stsc_pkg::ST_WRSP;
            end else begin
              st_r <= stsc_pkg::ST_DONE;
            end
          end
        end
        stsc_pkg::ST_RDSP: begin
          sh_r  <= {1'b0, sh_r[71:1]};
          cnt_r <= cnt_r + 7'd1;
          if (cnt_r == 7'd71) begin
            st_r <= stsc_pkg::ST_DONE;
          end
        end
        stsc_pkg::ST_WRSP: begin
          sh_r  <= nx;
          cnt_r <= cnt_r + 7'd1;
          if (cnt_r == 7'd15) begin
            st_r <= stsc_pkg::ST_DONE;
          end
        end
        default: begin
          st_r <= st_r;
        end
      endcase
    end
  end

  // conversion and copy run time; the strong pull-up is the master's job
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      busy_cnt_r <= '0;
      conv_r     <= 1'b0;
    end else if (go_conv) begin
      busy_cnt_r <= TW'(CONV_CYC);
      conv_r     <= 1'b1;
    end else if (go_copy) begin
      busy_cnt_r <= TW'(COPY_CYC);
    end else if (busy_cnt_r != '0) begin
      busy_cnt_r <= busy_cnt_r - 1'b1;
    end else begin
      conv_r <= 1'b0;
    end
  end

  assign conv_active = conv_r;

  // result capture and limit check, half-degree bit dropped
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      temp_r  <= '0;
      crem_r  <= '0;
      cpc_r   <= '0;
      alarm_r <= 1'b0;
    end else if (conv_r && busy_cnt_r == '0) begin
      temp_r  <= temp_code;
      crem_r  <= cnt_remain;
      cpc_r   <= cnt_per_c;
      alarm_r <= ($signed(temp_code[8:1]) >
                  $signed(upper_limit_trigger_r)) ||
                 ($signed(temp_code[8:1]) <
                  $signed(lower_limit_trigger_r));
    end
  end

  // scratchpad trigger bytes, written lsb first
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      upper_limit_trigger_r <= `STSC_UPPER_RST;
      lower_limit_trigger_r <= `STSC_LOWER_RST;
    end else if (bit_stb && st_r == stsc_pkg::ST_WRSP &&
                 cnt_r == 7'd15) begin
      upper_limit_trigger_r <= nx[63:56];
      lower_limit_trigger_r <= nx[71:64];
    end else if (fn_dec && op == OP_RECALL) begin
      upper_limit_trigger_r <= upper_limit_trigger_ee_r;
      lower_limit_trigger_r <= lower_limit_trigger_ee_r;
    end
  end

  // nonvolatile copy, kept across bus resets
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      upper_limit_trigger_ee_r <= `STSC_UPPER_RST;
      lower_limit_trigger_ee_r <= `STSC_LOWER_RST;
    end else if (go_copy) begin
      upper_limit_trigger_ee_r <= upper_limit_trigger_r;
      lower_limit_trigger_ee_r <= lower_limit_trigger_r;
    end
  end

  // local register port; bit 0 of control lets the device answer
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ctrl_r <= `STSC_CTRL_RST;
    end else if (reg_wr && reg_addr == `STSC_ADR_CTRL) begin
      ctrl_r <= reg_wdata;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      case (reg_addr)
        `STSC_ADR_STATUS: reg_rdata <= {4'h0,
                            st_r == stsc_pkg::ST_BUSY, conv_r, alarm_r,
                            st_r == stsc_pkg::ST_FNCMD};
        `STSC_ADR_CTRL:   reg_rdata <= ctrl_r;
        `STSC_ADR_TEMP:   reg_rdata <= temp_r[8:1];
        default:          reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule : stsc_ctrl
`default_nettype wire

/* include/stsc_params.svh */
/*
  constants of the single-wire temperature sensor controller.
  assumes a 40 MHz ref_clk; times are in ns, counts derived from them.
*/
// Summary of operation
// - memory and control commands are ignored until a selection command completes
// - after a good selection one of five memory/control commands is accepted
// - identity is 8-bit family, 48-bit serial, 8-bit check field
// - conversion command places the reading in the scratchpad for later read
// - two one-byte nonvolatile triggers, upper and lower
// - trigger bytes double as user storage when alarm search is unused
// - triggers are written by command and read back only via scratchpad
// - every data byte moves least significant bit first
// - reading is two's complement, half-degree steps, -55 to +100 degrees
// - each reading is a 9-bit value
// - a conversion takes typically 0.2 s before the result is ready
// - an 8-bit check value is computed over data sent
// - alarm search is answered only while the alarm flag is set
// - broadcast selection lets all devices convert together
// - link runs at a nominal 16.3 kbps on one data signal
// - alarm when reading without half bit is above upper or below lower
// - reading is presented as 16 bits, sign copied through upper byte
// - check values use x^8+x^5+x^4+1 from an all-zero start
`ifndef STSC_PARAMS_SVH
`define STSC_PARAMS_SVH

`define STSC_CLK_NS        25
`define STSC_UP(ns)        (((ns) + `STSC_CLK_NS - 1) / `STSC_CLK_NS)
`define STSC_DN(ns)        ((ns) / `STSC_CLK_NS)

`define STSC_RST_MIN_NS    480000
`define STSC_SAMPLE_NS     15000
`define STSC_TX_HOLD_NS    30000
`define STSC_PRES_WAIT_NS  30000
`define STSC_PRES_LEN_NS   120000
`define STSC_CONV_NS       200000000
`define STSC_COPY_NS       10000000

`define STSC_OP_READ_ID    8'h33
`define STSC_OP_MATCH_ID   8'h55
`define STSC_OP_SEARCH_ID  8'hF0
`define STSC_OP_SKIP_ID    8'hCC
`define STSC_OP_ALARM_SRCH 8'hEC
`define STSC_OP_CONVERT    8'h44
`define STSC_OP_RD_SCRATCH 8'hBE
`define STSC_OP_WR_SCRATCH 8'h4E
`define STSC_OP_COPY       8'h48
`define STSC_OP_RECALL     8'hB8

`define STSC_CRC_POLY      8'h8C
`define STSC_UPPER_RST     8'h7F
`define STSC_LOWER_RST     8'h80
`define STSC_PAD_BYTE      8'hFF

`define STSC_ADR_STATUS    2'h0
`define STSC_ADR_CTRL      2'h1
`define STSC_ADR_TEMP      2'h2
`define STSC_CTRL_RST      8'h01

`endif

/* include/stsc_pkg.sv */
/*
  types of the single-wire temperature sensor controller.
  assumes stsc_params.svh for all numeric constants.
*/
package stsc_pkg;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_ROMCMD,
    ST_READID,
    ST_MATCH,
    ST_SEARCH,
    ST_FNCMD,
    ST_RDSP,
    ST_WRSP,
    ST_BUSY,
    ST_DONE
  } stsc_state_t;

endpackage : stsc_pkg

/* dv/stsc_ctrl_sva.sv */
/* port checker for the sensor controller.
   assumes a bind from the bench and one ref_clk domain. */
`timescale 1ns/1ps
`default_nettype none
module stsc_ctrl_sva #(
  parameter int CONV_CYC = 200,
  parameter int PRES_LEN = 50
) (
  input wire logic       ref_clk,
  input wire logic       rst_n,
  input wire logic       dq_out,
  input wire logic       dq_oe,
  input wire logic       conv_active,
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata
);
  // presence may outlast a zero slot, so bound by the longer one
  localparam int OE_MAX = (PRES_LEN > 1200 ? PRES_LEN : 1200) + 4;
  int conv_n_r;
  int oe_n_r;
  always_ff @(posedge ref_clk) begin
    conv_n_r <= (!rst_n || !conv_active) ? 0 : conv_n_r + 1;
  end
  always_ff @(posedge ref_clk) begin
    oe_n_r <= (!rst_n || !dq_oe) ? 0 : oe_n_r + 1;
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence s_ctrl_wr;
    reg_wr && reg_addr == 2'h1;
  endsequence
  sequence s_ctrl_rd;
    reg_rd && reg_addr == 2'h1;
  endsequence
  a_pin_low_only: assert property (dq_out == 1'b0)
    else $error("data pin driven high");
  a_rdata_quiet: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data without read");
  a_unmapped_zero: assert property (
    reg_rd && reg_addr == 2'h3 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_ctrl_back: assert property (
    s_ctrl_wr ##3 s_ctrl_rd |=> reg_rdata[0] == $past(reg_wdata[0], 4))
    else $error("respond enable not kept");
  a_status_conv: assert property (
    reg_rd && reg_addr == 2'h0 |=>
      reg_rdata[2] == $past(conv_active) && reg_rdata[7:4] == 4'h0)
    else $error("status busy bits wrong");
  a_zero_hold: assert property ($rose(dq_oe) |-> dq_oe [*8])
    else $error("pull-down too short");
  a_oe_bounded: assert property (oe_n_r <= OE_MAX)
    else $error("pull-down too long");
  a_conv_bounded: assert property (conv_n_r <= CONV_CYC + 2)
    else $error("conversion too long");
  a_conv_full: assert property (
    $fell(conv_active) |-> conv_n_r + 2 >= CONV_CYC)
    else $error("conversion too short");
endmodule : stsc_ctrl_sva
`default_nettype wire

/* dv/stsc_bus_master.sv */
/* behavioural bus master for the single data line.
   assumes an external pull-up: the line is high unless someone pulls. */
`timescale 1ns/1ps
`default_nettype none
module stsc_bus_master #(
  parameter int RST_LEN = 150
) (
  input wire logic ref_clk,
  input wire logic dq,
  output logic     pull_low
);
  int stall_cnt;
  initial begin
    pull_low = 1'b0;
    stall_cnt = 0;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : cyc
  task automatic wait_high(input int lim);
    for (int i = 0; i < lim && !dq; i++) @(posedge ref_clk);
    if (!dq) stall_cnt++;
  endtask : wait_high
  task automatic bus_reset(output logic seen);
    @(posedge ref_clk);
    pull_low <= 1'b1;
    cyc(RST_LEN);
    pull_low <= 1'b0;
    seen = 1'b0;
    for (int i = 0; i < 2000 && !seen; i++) begin
      @(posedge ref_clk);
      seen = !dq;
    end
    wait_high(6000);
    cyc(20);
  endtask : bus_reset
  // slots last past the device sample point, so no slot is lost
  task automatic write_bit(input logic b);
    @(posedge ref_clk);
    pull_low <= 1'b1;
    cyc(b ? 5 : 615);
    pull_low <= 1'b0;
    cyc(b ? 615 : 5);
  endtask : write_bit
  task automatic read_bit(output logic b);
    @(posedge ref_clk);
    pull_low <= 1'b1;
    cyc(8);
    pull_low <= 1'b0;
    cyc(192);
    b = dq;
    cyc(420);
    wait_high(2000);
  endtask : read_bit
  task automatic write_byte(input logic [7:0] v);
    for (int i = 0; i < 8; i++) write_bit(v[i]);
  endtask : write_byte
  task automatic read_byte(output logic [7:0] v);
    for (int i = 0; i < 8; i++) read_bit(v[i]);
  endtask : read_byte
endmodule : stsc_bus_master
`default_nettype wire

/* dv/test_single_wire_temp_sensor_ctrl.sv */
/* self-checking bench for the sensor controller.
   assumes stsc_params.svh, the bus master model and the checker. */
`timescale 1ns/1ps
`default_nettype none
`include "stsc_params.svh"
module test_single_wire_temp_sensor_ctrl;
  typedef struct packed {
    logic       wr;
    logic [1:0] a;
    logic [7:0] d;
    logic [7:0] m;
    logic [7:0] e;
  } stsc_row_t;
  localparam stsc_row_t ROWS [8] = '{
    '{1'b0, 2'h0, 8'h00, 8'hFF, 8'h00},
    '{1'b0, 2'h1, 8'h00, 8'h01, 8'h01},
    '{1'b1, 2'h1, 8'h00, 8'h00, 8'h00},
    '{1'b0, 2'h1, 8'h00, 8'h01, 8'h00},
    '{1'b1, 2'h1, 8'h01, 8'h00, 8'h00},
    '{1'b0, 2'h1, 8'h00, 8'h01, 8'h01},
    '{1'b1, 2'h3, 8'hFF, 8'h00, 8'h00},
    '{1'b0, 2'h3, 8'h00, 8'hFF, 8'h00}
  };
  logic       ref_clk;
  logic       rst_n;
  wire logic  dq_line;
  logic       pull_low;
  logic       dq_oe;
  logic       dq_out;
  logic [8:0] temp_code;
  logic [7:0] cnt_remain;
  logic [7:0] cnt_per_c;
  logic       conv_active;
  logic [1:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_rdata;
  logic       seen;
  logic [7:0] rd;
  logic [7:0] crc;
  logic [7:0] exp_b [9];
  int         err_total;
  int         check_count;
  // released line floats to the pull-up level
  assign dq_line = !(dq_oe || pull_low);
  stsc_ctrl #(
    // bus reset must outlast a device zero (~1200 cycles low)
    .RST_CYC (1250),
    .PRES_LEN(50),
    .CONV_CYC(200),
    .COPY_CYC(100)
  ) dut (
    .ref_clk    (ref_clk),
    .rst_n      (rst_n),
    .dq_in      (dq_line),
    .dq_out     (dq_out),
    .dq_oe      (dq_oe),
    .temp_code  (temp_code),
    .cnt_remain (cnt_remain),
    .cnt_per_c  (cnt_per_c),
    .conv_active(conv_active),
    .reg_addr   (reg_addr),
    .reg_wdata  (reg_wdata),
    .reg_wr     (reg_wr),
    .reg_rd     (reg_rd),
    .reg_rdata  (reg_rdata)
  );
  stsc_bus_master #(.RST_LEN(1300)) mst (
    .ref_clk (ref_clk),
    .dq      (dq_line),
    .pull_low(pull_low)
  );
  task automatic check(input string what, input logic [7:0] got,
                       input logic [7:0] want);
    check_count++;
    if (got !== want) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, want, got);
    end
  endtask : check
  task automatic reg_io(input logic wr, input logic [1:0] a,
                        input logic [7:0] d, output logic [7:0] q);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= wr;
    reg_rd <= !wr;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    @(posedge ref_clk);
    q = reg_rdata;
  endtask : reg_io
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = !ref_clk;
  end
  initial begin
    repeat (150000) @(posedge ref_clk);
    err_total++;
    report_and_stop();
  end
  initial begin
    rst_n = 1'b0;
    reg_addr = 2'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    temp_code = 9'h032;
    cnt_remain = 8'h05;
    cnt_per_c = 8'h20;
    err_total = 0;
    check_count = 0;
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      reg_io(ROWS[i].wr, ROWS[i].a, ROWS[i].d, rd);
      if (ROWS[i].m != 8'h00) check("reg", rd & ROWS[i].m, ROWS[i].e);
    end
    $display("register rows done");
    mst.bus_reset(seen);
    check("presence", {7'h00, seen}, 8'h01);
    mst.write_byte(`STSC_OP_CONVERT);
    mst.cyc(100);
    check("unselected conv", {7'h00, conv_active}, 8'h00);
    $display("unselected command done");
    mst.bus_reset(seen);
    mst.write_byte(`STSC_OP_SKIP_ID);
    reg_io(1'b0, 2'h0, 8'h00, rd);
    check("selected", {7'h00, rd[0]}, 8'h01);
    mst.write_byte(`STSC_OP_WR_SCRATCH);
    mst.write_byte(8'hFF);
    mst.write_byte(8'h00);
    $display("trigger write done");
    mst.bus_reset(seen);
    mst.write_byte(`STSC_OP_SKIP_ID);
    mst.write_byte(`STSC_OP_CONVERT);
    check("conv start", {7'h00, conv_active}, 8'h01);
    // front end moves mid-conversion: only the end value may land
    temp_code <= 9'h1CE;
    cnt_remain <= 8'h7F;
    cnt_per_c <= 8'hFF;
    // line left released and high while the device converts
    for (int i = 0; i < 1000 && conv_active; i++) @(posedge ref_clk);
    check("conv end", {7'h00, conv_active}, 8'h00);
    reg_io(1'b0, 2'h0, 8'h00, rd);
    check("alarm", {7'h00, rd[1]}, 8'h01);
    reg_io(1'b0, 2'h2, 8'h00, rd);
    check("temp reg", rd, 8'hE7);
    $display("conversion done");
    mst.bus_reset(seen);
    mst.write_byte(`STSC_OP_SKIP_ID);
    mst.write_byte(`STSC_OP_RD_SCRATCH);
    exp_b = '{8'hCE, 8'hFF, 8'hFF, 8'h00, 8'hFF, 8'hFF, 8'h7F, 8'hFF, 8'h00};
    crc = 8'h00;
    for (int i = 0; i < 8; i++) begin
      for (int k = 0; k < 8; k++) begin
        crc = (crc >> 1) ^ ((crc[0] ^ exp_b[i][k]) ? 8'h8C : 8'h00);
      end
    end
    exp_b[8] = crc;
    for (int i = 0; i < 9; i++) begin
      mst.read_byte(rd);
      check("scratch", rd, exp_b[i]);
    end
    check("stalls", {7'h00, mst.stall_cnt == 0}, 8'h01);
    $display("scratch read done");
    reg_io(1'b1, 2'h1, 8'h00, rd);
    @(posedge ref_clk);
    rst_n <= 1'b0;
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    reg_io(1'b0, 2'h1, 8'h00, rd);
    check("ctrl after reset", rd, `STSC_CTRL_RST);
    reg_io(1'b0, 2'h0, 8'h00, rd);
    check("status after reset", rd, 8'h00);
    $display("mid-run reset done");
    report_and_stop();
  end
endmodule : test_single_wire_temp_sensor_ctrl
bind stsc_ctrl stsc_ctrl_sva #(
  .CONV_CYC(CONV_CYC),
  .PRES_LEN(PRES_LEN)
) u_sva (
  .ref_clk    (ref_clk),
  .rst_n      (rst_n),
  .dq_out     (dq_out),
  .dq_oe      (dq_oe),
  .conv_active(conv_active),
  .reg_addr   (reg_addr),
  .reg_wdata  (reg_wdata),
  .reg_wr     (reg_wr),
  .reg_rd     (reg_rd),
  .reg_rdata  (reg_rdata)
);
`default_nettype wire
